//--- rtl/fsroc_pkg.sv
// package: constants and carriers of the suspend/resume and otp controller
package fsroc_pkg;
  // timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int OTP_PROGRAM_TIME_NS = 200000;
  localparam int OTP_PROGRAM_CYCLES =
    (OTP_PROGRAM_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SUSPEND_LATENCY_NS = 7000;
  localparam int SUSPEND_LATENCY_CYCLES =
    (SUSPEND_LATENCY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int OTP_DUMMY_BITS = 8;

  // otp area
  localparam int OTP_BYTES = 65;
  localparam logic [6:0] OTP_LAST = 7'h40;
  localparam logic [6:0] OTP_PAST = 7'h41;
  localparam logic [7:0] OTP_ERASED = 8'hff;
  localparam int OTP_LOCK_BIT = 0;

  // serial frame bit counts
  localparam logic [9:0] CNT_OPCODE = 10'h008;
  localparam logic [9:0] CNT_BYTE1 = 10'h010;
  localparam logic [9:0] CNT_ADDR = 10'h020;
  localparam logic [9:0] CNT_DATA = 10'h028;
  localparam logic [9:0] CNT_MAX = 10'h3ff;

  // status and flag status bit positions
  localparam int SR_WIP = 0;
  localparam int SR_WEL = 1;
  localparam int FSR_PROT = 1;
  localparam int FSR_PSUS = 2;
  localparam int FSR_PGM_ERR = 4;
  localparam int FSR_ERS_ERR = 5;
  localparam int FSR_ESUS = 6;
  localparam int FSR_READY = 7;
  localparam logic [7:0] FSR_RESET = 8'h80;

  // opcodes
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_RDFSR = 8'h70;
  localparam logic [7:0] OP_CLFSR = 8'h50;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_WRNVCR = 8'hb1;
  localparam logic [7:0] OP_WRVCR = 8'h81;
  localparam logic [7:0] OP_WREVCR = 8'h61;
  localparam logic [7:0] OP_WRLOCK = 8'he5;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_SSE = 8'h20;
  localparam logic [7:0] OP_SE = 8'hd8;
  localparam logic [7:0] OP_BE = 8'hc7;
  localparam logic [7:0] OP_SUSP = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_OTP_RD = 8'h4b;
  localparam logic [7:0] OP_OTP_PGM = 8'h42;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_BUSY = 3'b001,
    ST_PSUS = 3'b010,
    ST_ESUS = 3'b011,
    ST_OTPW = 3'b100
  } fsroc_state_t;

  typedef enum logic [1:0] {
    ARR_PROG = 2'b00,
    ARR_SSE = 2'b01,
    ARR_SE = 2'b10,
    ARR_BE = 2'b11
  } fsroc_arr_kind_t;

  typedef struct packed {
    logic go;
    fsroc_arr_kind_t kind;
    logic [23:0] addr;
  } fsroc_arr_cmd_t;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [7:0] data;
  } fsroc_reg_wr_t;

  typedef struct packed {
    logic valid;
    logic unsure;
    logic [23:0] addr;
  } fsroc_rd_req_t;
endpackage

//--- rtl/fsroc_ctrl.sv
// module: command-state, suspend/resume and otp logic of a serial nor flash
//
// Contract
// R1 - erase resume skips lock re-check
// R2 - program-suspend reads allowed, suspended page unsure
// R3 - program-suspend: only volatile config writes
// R4 - one nesting level, resumes in reverse
// R5 - one state; standby accepts all but suspend and resume
// R6 - suspend only while program or erase busy
// R7 - status and flag reads in every state
// R8 - erase-suspend programs other sectors, not otp
// R9 - reads of suspended-erase sector accepted, unsure
// R10 - sector erases only in standby
// R11 - status, nonvolatile, otp program, bulk: standby
// R12 - enable, disable, clear, lock, volatile: not busy
// R13 - host frames resume with chip select
// R14 - resume sets busy, clears ready flag
// R15 - resume ignored when nothing suspended
// R16 - host sends otp read address, dummies
// R17 - otp read shifts on falls, address increments
// R18 - otp read address sticks at last byte
// R19 - chip select high ends read, output off
// R20 - otp program ignored without write enable
// R21 - host frames otp program bytes
// R22 - at most 65 bytes latched, rest dropped
// R23 - self-timed otp program holds busy
// R24 - control bit zero locks otp area
// R25 - otp end clears enable; timeout flags failure
// R26 - suspend flags, ready after latency
// R27 - two-entry record of suspended operations
`timescale 1ns/1ps
`default_nettype none
module fsroc_ctrl #(
  parameter int OTP_PROG_CYCLES = fsroc_pkg::OTP_PROGRAM_CYCLES,
  parameter int SUSP_CYCLES = fsroc_pkg::SUSPEND_LATENCY_CYCLES,
  parameter int OTP_DUMMY = fsroc_pkg::OTP_DUMMY_BITS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic serial_clock,
  input wire logic chip_select_n,
  input wire logic serial_in_line,
  output logic serial_out_line,
  output logic serial_out_oe,
  input wire logic array_done,
  input wire logic array_fail,
  input wire logic otp_timeout,
  output var fsroc_pkg::fsroc_arr_cmd_t array_cmd,
  output logic array_suspend,
  output logic array_resume,
  output logic array_resume_erase,
  output var fsroc_pkg::fsroc_reg_wr_t reg_write,
  output var fsroc_pkg::fsroc_rd_req_t read_req,
  output logic [7:0] status_reg,
  output logic [7:0] flag_status,
  output logic [2:0] dev_state
);
  localparam int TMAX = (OTP_PROG_CYCLES > SUSP_CYCLES) ? OTP_PROG_CYCLES : SUSP_CYCLES;
  localparam int TW = $clog2(TMAX + 1);
  localparam logic [TW-1:0] OTP_LOAD = TW'(OTP_PROG_CYCLES - 1);
  localparam logic [TW-1:0] SUSP_LOAD = TW'(SUSP_CYCLES - 1);
  localparam logic [9:0] RD_START = 10'(32 + OTP_DUMMY);

  ////////////////////////////////////////////////////////////////////////////
  // link synchronisers and edge detect
  logic [2:0] sck_p;
  logic [2:0] cs_p;
  logic [1:0] si_p;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sck_p <= 3'b000;
      cs_p <= 3'b111;
      si_p <= 2'b00;
    end else begin
      sck_p <= {sck_p[1:0], serial_clock};
      cs_p <= {cs_p[1:0], chip_select_n};
      si_p <= {si_p[0], serial_in_line};
    end
  end

  wire sck_rise = sck_p[1] & ~sck_p[2];
  wire sck_fall = ~sck_p[1] & sck_p[2];
  wire cs_low = ~cs_p[1];
  wire cs_rise = cs_p[1] & ~cs_p[2];
  wire si_s = si_p[1];

  ////////////////////////////////////////////////////////////////////////////
  // serial input framing
  logic [31:0] sreg;
  logic [9:0] cnt;
  logic [7:0] op;
  logic [7:0] dat;
  logic [23:0] addr;

  wire [31:0] next_sreg = {sreg[30:0], si_s};
  wire [9:0] next_cnt = (cnt == fsroc_pkg::CNT_MAX) ? cnt : cnt + 10'd1;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sreg <= 32'h0000_0000;
      cnt <= 10'h000;
      op <= 8'h00;
      dat <= 8'h00;
      addr <= 24'h00_0000;
    end else if (!cs_low) begin
      cnt <= 10'h000;
      op <= 8'h00;
    end else if (sck_rise) begin
      sreg <= next_sreg;
      cnt <= next_cnt;
      if (next_cnt == fsroc_pkg::CNT_OPCODE) begin
        op <= next_sreg[7:0];
      end
      if (next_cnt == fsroc_pkg::CNT_BYTE1) begin
        dat <= next_sreg[7:0];
      end
      if (next_cnt == fsroc_pkg::CNT_ADDR) begin
        addr <= next_sreg[23:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state, records and command acceptance
  fsroc_pkg::fsroc_state_t st;
  fsroc_pkg::fsroc_arr_kind_t erase_kind;
  logic busy_erase;
  logic susp_pend;
  logic erase_held;
  logic prog_held;
  logic [23:0] erase_addr;
  logic [15:0] prog_page;
  logic [TW-1:0] timer;
  logic wel;
  logic fsr_prot;
  logic fsr_pgm;
  logic fsr_ers;
  logic flag_psus;
  logic flag_esus;
  logic ready;
  logic [7:0] otp_mem [0:fsroc_pkg::OTP_BYTES-1];

  wire s_idle = (st == fsroc_pkg::ST_IDLE);
  wire s_busy = (st == fsroc_pkg::ST_BUSY);
  wire s_psus = (st == fsroc_pkg::ST_PSUS);
  wire s_esus = (st == fsroc_pkg::ST_ESUS);
  wire s_otpw = (st == fsroc_pkg::ST_OTPW);

  wire frame_ok = cs_rise & (cnt[2:0] == 3'd0);
  wire len0 = (cnt == fsroc_pkg::CNT_OPCODE);
  wire len1 = (cnt >= fsroc_pkg::CNT_BYTE1);
  wire len3 = (cnt == fsroc_pkg::CNT_ADDR);
  wire len4 = (cnt >= fsroc_pkg::CNT_DATA);

  wire ok_std = s_idle | s_psus | s_esus; // R12
  wire ok_lock = s_idle | s_esus; // R3
  wire ok_read = s_idle | s_psus | s_esus; // R2 R9
  wire sector_hit = erase_held & ((addr[23:16] == erase_addr[23:16]) |
                    (erase_kind == fsroc_pkg::ARR_BE));
  wire ok_prog = s_idle | (s_esus & ~sector_hit); // R5 R8

  wire c_wren = frame_ok & (op == fsroc_pkg::OP_WREN) & len0 & ok_std; // R12
  wire c_wrdi = frame_ok & (op == fsroc_pkg::OP_WRDI) & len0 & ok_std; // R12
  wire c_clfsr = frame_ok & (op == fsroc_pkg::OP_CLFSR) & len0 & ok_std; // R12
  wire c_pp_any = frame_ok & (op == fsroc_pkg::OP_PROG) & len4 & wel;
  wire c_pp = c_pp_any & ok_prog; // R8
  wire c_pp_hit = c_pp_any & s_esus & sector_hit; // R8
  wire c_sse = frame_ok & (op == fsroc_pkg::OP_SSE) & len3 & wel & s_idle; // R10
  wire c_se = frame_ok & (op == fsroc_pkg::OP_SE) & len3 & wel & s_idle; // R10
  wire c_be = frame_ok & (op == fsroc_pkg::OP_BE) & len0 & wel & s_idle; // R11
  wire c_susp = frame_ok & (op == fsroc_pkg::OP_SUSP) & len0 & s_busy & ~susp_pend; // R6
  wire c_res = frame_ok & (op == fsroc_pkg::OP_RESUME) & len0 & (s_psus | s_esus); // R13 R15
  wire c_potp = frame_ok & (op == fsroc_pkg::OP_OTP_PGM) & len4 & wel & s_idle; // R11 R20
  wire otp_locked = ~otp_mem[fsroc_pkg::OTP_BYTES-1][fsroc_pkg::OTP_LOCK_BIT];
  wire potp_go = c_potp & ~otp_locked; // R24
  wire potp_lock = c_potp & otp_locked; // R24
  wire wr_nv = ((op == fsroc_pkg::OP_WRSR) | (op == fsroc_pkg::OP_WRNVCR)) & s_idle; // R11
  wire wr_vol = ((op == fsroc_pkg::OP_WRVCR) | (op == fsroc_pkg::OP_WREVCR)) & ok_std; // R3
  wire wr_lock = (op == fsroc_pkg::OP_WRLOCK) & ok_lock; // R3 R12
  wire c_regw = frame_ok & len1 & wel & (wr_nv | wr_vol | wr_lock);

  wire arr_start = c_pp | c_sse | c_se | c_be;
  wire timer_zero = (timer == '0);
  wire op_end = s_busy & array_done;
  wire susp_done = s_busy & susp_pend & timer_zero & ~array_done; // R26
  wire otp_end = s_otpw & (timer_zero | otp_timeout); // R23
  wire otp_commit = s_otpw & timer_zero & ~otp_timeout;

  fsroc_pkg::fsroc_arr_kind_t arr_kind;
  assign arr_kind = c_pp ? fsroc_pkg::ARR_PROG :
                    c_sse ? fsroc_pkg::ARR_SSE :
                    c_se ? fsroc_pkg::ARR_SE : fsroc_pkg::ARR_BE;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= fsroc_pkg::ST_IDLE;
      busy_erase <= 1'b0;
      susp_pend <= 1'b0;
      erase_held <= 1'b0;
      prog_held <= 1'b0;
      timer <= '0;
    end else begin
      case (st)
        fsroc_pkg::ST_IDLE: begin
          if (arr_start) begin
            st <= fsroc_pkg::ST_BUSY; // R5
            busy_erase <= ~c_pp;
          end else if (potp_go) begin
            st <= fsroc_pkg::ST_OTPW; // R23
            timer <= OTP_LOAD;
          end
        end
        fsroc_pkg::ST_BUSY: begin
          if (array_done) begin
            st <= (erase_held & ~busy_erase) ? fsroc_pkg::ST_ESUS : fsroc_pkg::ST_IDLE; // R4
            susp_pend <= 1'b0;
          end else if (c_susp) begin
            susp_pend <= 1'b1;
            timer <= SUSP_LOAD; // R26
          end else if (susp_done) begin
            susp_pend <= 1'b0;
            st <= busy_erase ? fsroc_pkg::ST_ESUS : fsroc_pkg::ST_PSUS;
            erase_held <= erase_held | busy_erase; // R27
            prog_held <= ~busy_erase; // R27
          end else if (susp_pend) begin
            timer <= timer - TW'(1);
          end
        end
        fsroc_pkg::ST_PSUS: begin
          if (c_res) begin
            st <= fsroc_pkg::ST_BUSY; // R4
            busy_erase <= 1'b0;
            prog_held <= 1'b0;
          end
        end
        fsroc_pkg::ST_ESUS: begin
          if (c_pp) begin
            st <= fsroc_pkg::ST_BUSY; // R8
            busy_erase <= 1'b0;
          end else if (c_res) begin
            st <= fsroc_pkg::ST_BUSY; // R1 R4
            busy_erase <= 1'b1;
            erase_held <= 1'b0;
          end
        end
        fsroc_pkg::ST_OTPW: begin
          if (otp_end) begin
            st <= fsroc_pkg::ST_IDLE;
          end else begin
            timer <= timer - TW'(1);
          end
        end
        default: begin
          st <= fsroc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // addresses of the operations that may be suspended
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      erase_addr <= 24'h00_0000;
      erase_kind <= fsroc_pkg::ARR_SE;
      prog_page <= 16'h0000;
    end else if (c_pp) begin
      prog_page <= addr[23:8]; // R27
    end else if (arr_start) begin
      erase_addr <= addr; // R27
      erase_kind <= arr_kind;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write enable latch and flag status bits; a set beats a clear
  wire wel_clr = arr_start | c_regw | c_wrdi | otp_end; // R25
  wire set_prot = potp_lock; // R24
  wire set_pgm = potp_lock | c_pp_hit | (op_end & array_fail & ~busy_erase) |
                 (otp_end & otp_timeout); // R24 R25
  wire set_ers = op_end & array_fail & busy_erase;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wel <= 1'b0;
      fsr_prot <= 1'b0;
      fsr_pgm <= 1'b0;
      fsr_ers <= 1'b0;
      flag_psus <= 1'b0;
      flag_esus <= 1'b0;
      ready <= fsroc_pkg::FSR_RESET[fsroc_pkg::FSR_READY];
    end else begin
      wel <= c_wren | (wel & ~wel_clr); // R20 R24
      fsr_prot <= set_prot | (fsr_prot & ~c_clfsr);
      fsr_pgm <= set_pgm | (fsr_pgm & ~c_clfsr);
      fsr_ers <= set_ers | (fsr_ers & ~c_clfsr);
      flag_psus <= (c_susp & ~busy_erase) |
                   (flag_psus & ~(op_end & ~busy_erase) & ~(c_res & s_psus)); // R26
      flag_esus <= (c_susp & busy_erase) |
                   (flag_esus & ~(op_end & busy_erase) & ~(c_res & s_esus)); // R26
      if (susp_done | op_end | otp_end) begin
        ready <= 1'b1; // R26
      end else if (arr_start | c_res | potp_go) begin
        ready <= 1'b0; // R14
      end
    end
  end

  logic [7:0] sr_w;
  logic [7:0] fsr_w;
  always_comb begin
    sr_w = 8'h00;
    sr_w[fsroc_pkg::SR_WIP] = s_busy | s_otpw; // R14 R23
    sr_w[fsroc_pkg::SR_WEL] = wel;
    fsr_w = 8'h00;
    fsr_w[fsroc_pkg::FSR_PROT] = fsr_prot;
    fsr_w[fsroc_pkg::FSR_PSUS] = flag_psus;
    fsr_w[fsroc_pkg::FSR_PGM_ERR] = fsr_pgm;
    fsr_w[fsroc_pkg::FSR_ERS_ERR] = fsr_ers;
    fsr_w[fsroc_pkg::FSR_ESUS] = flag_esus;
    fsr_w[fsroc_pkg::FSR_READY] = ready;
  end

  ////////////////////////////////////////////////////////////////////////////
  // otp area, program buffer and write pointer
  logic [6:0] wr_ptr;
  logic [7:0] pbuf [0:fsroc_pkg::OTP_BYTES-1];
  logic [fsroc_pkg::OTP_BYTES-1:0] pmask;

  wire otp_addr_in = (next_sreg[23:7] == 17'h0_0000) & (next_sreg[6:0] <= fsroc_pkg::OTP_LAST);
  wire potp_frame = cs_low & sck_rise & (op == fsroc_pkg::OP_OTP_PGM) & ~s_otpw;
  wire buf_clr = potp_frame & (next_cnt == fsroc_pkg::CNT_ADDR);
  wire byte_in = potp_frame & (next_cnt >= fsroc_pkg::CNT_DATA) & (next_cnt[2:0] == 3'd0);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= fsroc_pkg::OTP_PAST;
    end else if (buf_clr) begin
      wr_ptr <= otp_addr_in ? next_sreg[6:0] : fsroc_pkg::OTP_PAST; // R22
    end else if (byte_in && wr_ptr != fsroc_pkg::OTP_PAST) begin
      wr_ptr <= wr_ptr + 7'd1; // R22
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < fsroc_pkg::OTP_BYTES; gi++) begin : g_otp
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          pmask[gi] <= 1'b0;
          pbuf[gi] <= fsroc_pkg::OTP_ERASED;
          otp_mem[gi] <= fsroc_pkg::OTP_ERASED;
        end else begin
          if (otp_commit && pmask[gi]) begin
            otp_mem[gi] <= otp_mem[gi] & pbuf[gi]; // R23 R24
          end
          if (buf_clr) begin
            pmask[gi] <= 1'b0;
          end else if (byte_in && wr_ptr == 7'(gi)) begin
            pbuf[gi] <= next_sreg[7:0]; // R22
            pmask[gi] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // serial output: status, flag status and otp read data
  logic [6:0] rd_ptr;
  logic [7:0] out_sh;
  logic [2:0] obit;

  wire is_otp_rd = (op == fsroc_pkg::OP_OTP_RD);
  wire is_st_rd = (op == fsroc_pkg::OP_RDSR) | (op == fsroc_pkg::OP_RDFSR);
  wire out_on = cs_low & ((is_otp_rd & ok_read & (cnt >= RD_START)) |
                (is_st_rd & (cnt >= fsroc_pkg::CNT_OPCODE))); // R7 R16
  wire [7:0] byte_sel = is_otp_rd ? otp_mem[rd_ptr] :
                        (op == fsroc_pkg::OP_RDFSR) ? fsr_w : sr_w;
  wire [6:0] rd_next = (rd_ptr == fsroc_pkg::OTP_LAST) ? fsroc_pkg::OTP_LAST : rd_ptr + 7'd1;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_ptr <= 7'h00;
      out_sh <= 8'h00;
      obit <= 3'd0;
      serial_out_line <= 1'b0;
      serial_out_oe <= 1'b0;
    end else if (!cs_low) begin
      obit <= 3'd0;
      serial_out_oe <= 1'b0; // R19
    end else begin
      if (sck_rise && next_cnt == fsroc_pkg::CNT_ADDR) begin
        rd_ptr <= otp_addr_in ? next_sreg[6:0] : fsroc_pkg::OTP_LAST;
      end
      if (sck_fall && out_on) begin
        serial_out_oe <= 1'b1;
        obit <= obit + 3'd1;
        if (obit == 3'd0) begin
          serial_out_line <= byte_sel[7]; // R17
          out_sh <= {byte_sel[6:0], 1'b0};
          if (is_otp_rd) begin
            rd_ptr <= rd_next; // R17 R18
          end
        end else begin
          serial_out_line <= out_sh[7];
          out_sh <= {out_sh[6:0], 1'b0};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  wire rd_go = cs_low & sck_rise & (next_cnt == fsroc_pkg::CNT_ADDR) &
               (op == fsroc_pkg::OP_READ) & ok_read; // R2 R9
  wire rd_unsure = (prog_held & (next_sreg[23:8] == prog_page)) |
                   (erase_held & ((next_sreg[23:16] == erase_addr[23:16]) |
                   (erase_kind == fsroc_pkg::ARR_BE))); // R2 R9

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      array_cmd <= '0;
      array_suspend <= 1'b0;
      array_resume <= 1'b0;
      array_resume_erase <= 1'b0;
      reg_write <= '0;
      read_req <= '0;
      status_reg <= 8'h00;
      flag_status <= fsroc_pkg::FSR_RESET;
      dev_state <= fsroc_pkg::ST_IDLE;
    end else begin
      array_cmd.go <= arr_start;
      array_cmd.kind <= arr_kind;
      array_cmd.addr <= addr;
      array_suspend <= c_susp; // R6
      array_resume <= c_res; // R14
      array_resume_erase <= c_res & s_esus; // R1
      reg_write.valid <= c_regw;
      reg_write.opcode <= op;
      reg_write.data <= dat;
      read_req.valid <= rd_go;
      read_req.unsure <= rd_unsure;
      read_req.addr <= next_sreg[23:0];
      status_reg <= sr_w;
      flag_status <= fsr_w;
      dev_state <= st;
    end
  end
endmodule
`default_nettype wire

//--- bench/fsroc_host.sv
// host model: serial master that frames commands on the link
`timescale 1ns/1ps
`default_nettype none
module fsroc_host (
  input wire logic clk,
  output logic serial_clock,
  output logic chip_select_n,
  output logic serial_in_line,
  input wire logic serial_out_line
);
  initial begin
    serial_clock = 1'b0;
    chip_select_n = 1'b1;
    serial_in_line = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  // one frame: n bits out msb first, bits in taken late in the high phase
  task automatic xfer(input logic [79:0] tx, input int n, output logic [63:0] rx);
    rx = '0;
    @(posedge clk);
    chip_select_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      serial_in_line <= tx[i];
      repeat (4) @(posedge clk);
      serial_clock <= 1'b1;
      repeat (4) @(posedge clk);
      rx = {rx[62:0], serial_out_line};
      serial_clock <= 1'b0;
    end
    repeat (4) @(posedge clk);
    chip_select_n <= 1'b1;
    serial_in_line <= ~serial_in_line;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

//--- bench/fsroc_ctrl_assertions.sv
// checker: port-level assertions of the command-state controller
`timescale 1ns/1ps
`default_nettype none
module fsroc_ctrl_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic chip_select_n,
  input wire logic serial_out_oe,
  input wire fsroc_pkg::fsroc_arr_cmd_t array_cmd,
  input wire logic array_suspend,
  input wire logic array_resume,
  input wire logic array_resume_erase,
  input wire logic [7:0] status_reg,
  input wire logic [7:0] flag_status,
  input wire logic [2:0] dev_state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_state_legal: assert property (dev_state <= 3'h4)
    else $error("device state out of range");
  a_psus_flags: assert property (dev_state == fsroc_pkg::ST_PSUS |->
    flag_status[2] && flag_status[7]) else $error("program suspend flags missing");
  a_esus_flags: assert property (dev_state == fsroc_pkg::ST_ESUS |->
    flag_status[6] && flag_status[7]) else $error("erase suspend flags missing");
  a_suspend_busy: assert property (array_suspend |-> dev_state == fsroc_pkg::ST_BUSY)
    else $error("suspend accepted outside busy");
  a_resume_state: assert property (array_resume |=> dev_state == fsroc_pkg::ST_BUSY)
    else $error("resume did not restart work");
  a_resume_flags: assert property (array_resume |-> ##[0:2]
    (status_reg[0] && !flag_status[7])) else $error("resume busy flags wrong");
  a_resume_pair: assert property (array_resume_erase |-> array_resume)
    else $error("erase resume without resume pulse");
  a_erase_idle: assert property (array_cmd.go &&
    array_cmd.kind inside {fsroc_pkg::ARR_SSE, fsroc_pkg::ARR_SE}
    |-> $past(dev_state, 4) == fsroc_pkg::ST_IDLE) else $error("erase started outside standby");
  a_otp_busy: assert property (dev_state == fsroc_pkg::ST_OTPW |-> status_reg[0])
    else $error("otp program without busy");
  a_otp_done: assert property ($fell(dev_state == fsroc_pkg::ST_OTPW) |-> ##[0:2]
    (!status_reg[1] && !status_reg[0])) else $error("otp end left enable or busy");
  a_oe_release: assert property (chip_select_n [*8] |-> !serial_out_oe)
    else $error("output driven while deselected");
endmodule
bind fsroc_ctrl fsroc_ctrl_assertions chk (.clk(clk), .rst_n(rst_n),
  .chip_select_n(chip_select_n), .serial_out_oe(serial_out_oe), .array_cmd(array_cmd),
  .array_suspend(array_suspend), .array_resume(array_resume),
  .array_resume_erase(array_resume_erase), .status_reg(status_reg),
  .flag_status(flag_status), .dev_state(dev_state));
`default_nettype wire

//--- bench/test_fsroc_ctrl.sv
// testbench: command states, suspend nesting and otp area
`timescale 1ns/1ps
`default_nettype none
module test_fsroc_ctrl;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic array_done = 1'b0;
  logic array_fail = 1'b0;
  logic otp_timeout = 1'b0;
  logic sclk, csn, sin, sout, oe, susp, res, res_erase, res_seen, uns_seen;
  logic [1:0] kind_seen;
  logic [7:0] status_reg, flag_status, wr_seen;
  fsroc_pkg::fsroc_reg_wr_t regw;
  fsroc_pkg::fsroc_rd_req_t rdq;
  logic [2:0] dev_state;
  logic [63:0] rx;
  fsroc_pkg::fsroc_arr_cmd_t array_cmd;
  int fail_count = 0;
  int checks_done = 0;
  always #2 clk = ~clk;
  fsroc_host host (.clk(clk), .serial_clock(sclk), .chip_select_n(csn),
    .serial_in_line(sin), .serial_out_line(sout));
  fsroc_ctrl #(.OTP_PROG_CYCLES(20), .SUSP_CYCLES(10)) dut (.clk(clk), .rst_n(rst_n),
    .serial_clock(sclk), .chip_select_n(csn), .serial_in_line(sin),
    .serial_out_line(sout), .serial_out_oe(oe), .array_done(array_done),
    .array_fail(array_fail), .otp_timeout(otp_timeout), .array_cmd(array_cmd),
    .array_suspend(susp), .array_resume(res), .array_resume_erase(res_erase),
    .reg_write(regw), .read_req(rdq), .status_reg(status_reg), .flag_status(flag_status),
    .dev_state(dev_state));
  always @(posedge clk) begin
    if (res) res_seen <= res_erase;
    if (array_cmd.go) kind_seen <= array_cmd.kind;
    if (regw.valid) wr_seen <= regw.opcode;
    if (rdq.valid) uns_seen <= rdq.unsure;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic send(input logic [79:0] tx, input int n);
    host.xfer(tx, n, rx);
  endtask
  task automatic rd(input logic [7:0] op, input logic [7:0] exp);
    send({op, 8'h00}, 16);
    chk("register read", exp, rx[7:0]);
  endtask
  task automatic wait_state(input logic [2:0] exp, input int lim);
    for (int i = 0; i < lim && dev_state !== exp; i++) @(posedge clk);
    chk("state", {5'h00, exp}, {5'h00, dev_state});
  endtask
  task automatic done_pulse;
    @(posedge clk);
    array_done <= 1'b1;
    @(posedge clk);
    array_done <= 1'b0;
  endtask
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("flags", 8'h80, flag_status);
    send(fsroc_pkg::OP_RESUME, 8);
    send(fsroc_pkg::OP_SUSP, 8);
    wait_state(fsroc_pkg::ST_IDLE, 1);
    send({fsroc_pkg::OP_OTP_PGM, 24'h00_003e, 8'ha5}, 40);
    chk("flags", 8'h80, flag_status);
    send(fsroc_pkg::OP_WREN, 8);
    rd(fsroc_pkg::OP_RDSR, 8'h02);
    send(fsroc_pkg::OP_WRDI, 8);
    rd(fsroc_pkg::OP_RDSR, 8'h00);
    send(fsroc_pkg::OP_WREN, 8);
    send({fsroc_pkg::OP_OTP_PGM, 24'h00_003e, 32'ha55a_8177}, 64);
    wait_state(fsroc_pkg::ST_OTPW, 8);
    wait_state(fsroc_pkg::ST_IDLE, 40);
    chk("status", 8'h00, status_reg);
    send({fsroc_pkg::OP_OTP_RD, 24'h00_003e, 8'h00, 32'h0000_0000}, 72);
    chk("otp word lo", 8'ha5, rx[31:24]);
    chk("otp word hi", 8'h5a, rx[23:16]);
    chk("otp control", 8'h81, rx[15:8]);
    chk("otp saturate", 8'h81, rx[7:0]);
    send(fsroc_pkg::OP_WREN, 8);
    send({fsroc_pkg::OP_OTP_PGM, 24'h00_0000, 8'h00}, 40);
    otp_timeout <= 1'b1;
    wait_state(fsroc_pkg::ST_IDLE, 4);
    otp_timeout <= 1'b0;
    chk("flags", 8'h90, flag_status);
    send(fsroc_pkg::OP_WREN, 8);
    send({fsroc_pkg::OP_OTP_PGM, 24'h00_0040, 8'h80}, 40);
    wait_state(fsroc_pkg::ST_OTPW, 8);
    wait_state(fsroc_pkg::ST_IDLE, 40);
    send(fsroc_pkg::OP_WREN, 8);
    send({fsroc_pkg::OP_OTP_PGM, 24'h00_0000, 8'h00}, 40);
    wait_state(fsroc_pkg::ST_IDLE, 1);
    chk("flags", 8'h92, flag_status);
    chk("status", 8'h02, status_reg);
    send(fsroc_pkg::OP_CLFSR, 8);
    chk("flags", 8'h80, flag_status);
    send({fsroc_pkg::OP_SE, 24'h01_0000}, 32);
    wait_state(fsroc_pkg::ST_BUSY, 8);
    chk("array kind", {6'h00, fsroc_pkg::ARR_SE}, {6'h00, kind_seen});
    send(fsroc_pkg::OP_WREN, 8);
    rd(fsroc_pkg::OP_RDSR, 8'h01);
    send(fsroc_pkg::OP_SUSP, 8);
    wait_state(fsroc_pkg::ST_ESUS, 30);
    rd(fsroc_pkg::OP_RDFSR, 8'hc0);
    send(fsroc_pkg::OP_WREN, 8);
    send({fsroc_pkg::OP_SSE, 24'h02_0000}, 32);
    wait_state(fsroc_pkg::ST_ESUS, 1);
    send({fsroc_pkg::OP_PROG, 24'h01_0000, 8'h00}, 40);
    chk("flags", 8'hd0, flag_status);
    send({fsroc_pkg::OP_PROG, 24'h02_0000, 8'h00}, 40);
    wait_state(fsroc_pkg::ST_BUSY, 8);
    chk("array kind", {6'h00, fsroc_pkg::ARR_PROG}, {6'h00, kind_seen});
    send(fsroc_pkg::OP_SUSP, 8);
    wait_state(fsroc_pkg::ST_PSUS, 30);
    chk("suspend flags", 8'h44, flag_status & 8'h44);
    send(fsroc_pkg::OP_WREN, 8);
    send({fsroc_pkg::OP_WRLOCK, 8'h5a}, 16);
    send({fsroc_pkg::OP_WRVCR, 8'h5a}, 16);
    chk("register write", 8'h81, wr_seen);
    send({fsroc_pkg::OP_READ, 24'h02_0000}, 32);
    chk("read unsure", 8'h01, {7'h00, uns_seen});
    send(fsroc_pkg::OP_RESUME, 8);
    wait_state(fsroc_pkg::ST_BUSY, 8);
    chk("resumed erase", 8'h00, {7'h00, res_seen});
    chk("busy flags", 8'h01, {6'h00, flag_status[7], status_reg[0]});
    done_pulse();
    wait_state(fsroc_pkg::ST_ESUS, 8);
    send(fsroc_pkg::OP_RESUME, 8);
    wait_state(fsroc_pkg::ST_BUSY, 8);
    chk("resumed erase", 8'h01, {7'h00, res_seen});
    done_pulse();
    wait_state(fsroc_pkg::ST_IDLE, 8);
    send(fsroc_pkg::OP_RESUME, 8);
    wait_state(fsroc_pkg::ST_IDLE, 1);
    finish_test();
  end
endmodule
`default_nettype wire
